// *** common/fsi_pkg.sv ***
package fsi_pkg;

  // ****************************************
  // Array organisation
  // ****************************************

  // Byte offset bits inside a page, a sector, a half block and a full block.
  localparam int          FSI_PAGE_SHIFT   = 8;
  localparam int          FSI_SECTOR_SHIFT = 12;
  localparam int          FSI_BLK32_SHIFT  = 15;
  localparam int          FSI_BLK64_SHIFT  = 16;
  // Sector count, the first byte of the top sector and the last byte of the 4-Mbit array.
  localparam int          FSI_SECTOR_COUNT = 128;
  localparam logic [23:0] FSI_TOP_SECTOR   = 24'h07f000;
  localparam logic [23:0] FSI_LAST_ADDR    = 24'h07ffff;

  // ****************************************
  // Framing
  // ****************************************

  // Bits in a byte, index of the last of the three address bytes after the opcode.
  localparam logic [3:0]  FSI_BYTE_BITS  = 4'h8;
  localparam logic [1:0]  FSI_ADDR_LAST  = 2'h2;

  // ****************************************
  // Opcodes
  // ****************************************

  // Single-lane commands that carry no address.
  localparam logic [7:0] FSI_PLAIN_OPS [20] = '{
    8'h06, 8'h04, 8'h50, 8'h05, 8'h35, 8'h25, 8'h01, 8'h77, 8'h60, 8'hc7,
    8'hb9, 8'hab, 8'h9f, 8'h75, 8'hb0, 8'h7a, 8'h30, 8'h66, 8'h99, 8'hff};
  // Single-lane commands followed by a three-byte address.
  localparam logic [7:0] FSI_ADDR_OPS [13] = '{
    8'h03, 8'h0b, 8'h81, 8'h20, 8'h52, 8'hd8, 8'h02, 8'h90, 8'h44, 8'h42,
    8'h48, 8'h4b, 8'h5a};
  // Multi-lane commands.
  localparam logic [7:0] FSI_OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] FSI_OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0] FSI_OP_DUAL_ID  = 8'h92;
  localparam logic [7:0] FSI_OP_DUAL_PP  = 8'ha2;
  localparam logic [7:0] FSI_OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] FSI_OP_QUAD_IO  = 8'heb;
  localparam logic [7:0] FSI_OP_QUAD_ID  = 8'h94;
  localparam logic [7:0] FSI_OP_QUAD_PP  = 8'h32;

  // Lane counts.
  localparam logic [3:0] FSI_W1 = 4'h1;
  localparam logic [3:0] FSI_W2 = 4'h2;
  localparam logic [3:0] FSI_W4 = 4'h4;

  // ****************************************
  // Types
  // ****************************************

  // How a command uses the lanes.
  typedef enum logic [3:0] {
    CL_BAD, CL_PLAIN, CL_SADDR, CL_DUAL_OUT, CL_DUAL_IO, CL_DUAL_IN,
    CL_QUAD_OUT, CL_QUAD_IO, CL_QUAD_IN
  } fsi_class_t;

  // Frame states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_STANDBY
  } fsi_state_t;

endpackage

// *** common/fsi_stream_if.sv ***
`timescale 1ns/1ns
// Valid/ready byte stream between the frame logic and the receive FIFO.
interface fsi_stream_if #(
  parameter int W = 9
);
  logic         valid;  // Word offered.
  logic         ready;  // Word can be taken.
  logic [W-1:0] data;   // Word itself.

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** design/fsi_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for pins that come from outside the clock domain.
module fsi_sync #(
  parameter int           W   = 6,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         reset,
  // Pins and their synchronised copy.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by the second.
    logic [W-1:0] s2;  // Second stage, safe to use.
  } fsi_sync_t;

  fsi_sync_t st;       // Registered state.
  fsi_sync_t next_st;  // Next state.

  // The second stage only ever looks at the first.
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Register the copy.
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '{s1: RST, s2: RST};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule

// *** design/fsi_fifo.sv ***
`timescale 1ns/1ns
// Small FIFO with registered flags and a registered head word.
module fsi_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         reset,
  // Filling side.
  fsi_stream_if.snk         push,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage words.
    logic [AW-1:0]       wr;    // Write index.
    logic [AW-1:0]       rd;    // Read index.
    logic [AW:0]         cnt;   // Words held.
    logic                rdy;   // Room for one more.
    logic                vld;   // Head word present.
    logic [W-1:0]        head;  // Copy of the head word.
  } fsi_fifo_t;

  fsi_fifo_t st;       // Registered state.
  fsi_fifo_t next_st;  // Next state.

  // Flags are recomputed from the next count so they stay honest.
  always_comb begin
    logic take;
    logic give;
    take    = push.valid && st.rdy;
    give    = st.vld && out_ready;
    next_st = st;
    if (take) begin
      next_st.mem[st.wr] = push.data;
      next_st.wr         = (st.wr == AW'(D - 1)) ? '0 : st.wr + 1'b1;
    end
    if (give) begin
      next_st.rd = (st.rd == AW'(D - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt  = st.cnt + {{AW{1'b0}}, take} - {{AW{1'b0}}, give};
    next_st.rdy  = next_st.cnt != (AW+1)'(D);
    next_st.vld  = next_st.cnt != '0;
    next_st.head = next_st.mem[next_st.rd];
  end

  // Register the copy; an empty FIFO with room after reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '{mem: '0, wr: '0, rd: '0, cnt: '0, rdy: 1'b1, vld: 1'b0, head: '0};
    end else begin
      st <= next_st;
    end
  end

  assign push.ready = st.rdy;
  assign out_valid  = st.vld;
  assign out_data   = st.head;

endmodule

// *** design/fsi_frontend.sv ***
`timescale 1ns/1ns
// What this block does
// - Pages, sectors and blocks split the address.
// - Sectors are consecutive 4K ranges from zero.
// - Unknown opcode: standby, lanes released, until reselect.
// - Known opcode: active until select rises.
// - Sample on clock rise, shift on fall.
// - Either clock idle level at select.
// - Dual read opcodes use two lanes.
// - Two-lane commands move two bits per clock.
// - Quad read opcodes use four lanes.
// - Four-lane commands move four bits per clock.
// - Four-lane opcodes need four_lane_enable set.
// - Pause never stops a running operation.
// - Pause starts at pause low, clock low.
// - Pause ends at pause high, clock low.
// - Output released while pause is low.
// - Inputs ignored while paused.
// - Select high during pause resets interface.
// - No pause in four-lane mode.
// - four_lane_enable turns pins into lane2, lane3.
// - busy_flag follows the program/erase engine.
module fsi_frontend
  import fsi_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Link pins.
  input  wire logic        serial_clock,
  input  wire logic        select_n,
  input  wire logic        lane0_in,
  output logic             lane0_out,
  output logic             lane0_oe,
  input  wire logic        lane1_in,
  output logic             lane1_out,
  output logic             lane1_oe,
  input  wire logic        lane2_in,
  output logic             lane2_out,
  output logic             lane2_oe,
  input  wire logic        lane3_in,
  output logic             lane3_out,
  output logic             lane3_oe,
  // Configuration and engine status.
  input  wire logic        four_lane_enable,
  input  wire logic        engine_busy,
  output logic             busy_flag,
  // Command and address report.
  output logic             cmd_valid,
  output logic      [7:0]  cmd_opcode,
  output logic             addr_valid,
  output logic      [23:0] cmd_addr,
  output logic      [10:0] addr_page,
  output logic      [6:0]  addr_sector,
  output logic      [3:0]  addr_half_block,
  output logic      [2:0]  addr_block,
  output logic             addr_ok,
  // Frame status.
  output logic             link_active,
  output logic             link_standby,
  output logic             paused,
  // Received bytes, bit 8 marks the opcode.
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [8:0]  rx_data,
  output logic             rx_room,
  output logic             rx_overrun,
  // Bytes to send.
  input  wire logic [7:0]  tx_byte,
  output logic             tx_take
);

  // ****************************************
  // Pin synchronisers and receive FIFO
  // ****************************************

  logic [5:0] pins;  // {lane3..lane0, select_n, serial_clock} synchronised.

  fsi_sync #(.W(6), .RST(6'h02)) u_sync (
    .clock (clock),
    .reset (reset),
    .d     ({lane3_in, lane2_in, lane1_in, lane0_in, select_n, serial_clock}),
    .q     (pins)
  );

  fsi_stream_if #(.W(9)) rx_if ();

  fsi_fifo #(.W(9), .D(DEPTH)) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .push      (rx_if),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ****************************************
  // Helpers
  // ****************************************

  // Lane use of an opcode; four-lane ones only with the enable set.
  function automatic fsi_class_t decode(input logic [7:0] op, input logic qe);
    fsi_class_t c;
    c = CL_BAD;
    foreach (FSI_PLAIN_OPS[i]) if (op == FSI_PLAIN_OPS[i]) c = CL_PLAIN;
    foreach (FSI_ADDR_OPS[i]) if (op == FSI_ADDR_OPS[i]) c = CL_SADDR;
    case (op)
      FSI_OP_DUAL_OUT: c = CL_DUAL_OUT;
      FSI_OP_DUAL_IO:  c = CL_DUAL_IO;
      FSI_OP_DUAL_ID:  c = CL_DUAL_IO;
      FSI_OP_DUAL_PP:  c = CL_DUAL_IN;
      FSI_OP_QUAD_OUT: c = qe ? CL_QUAD_OUT : CL_BAD;
      FSI_OP_QUAD_IO:  c = qe ? CL_QUAD_IO : CL_BAD;
      FSI_OP_QUAD_ID:  c = qe ? CL_QUAD_IO : CL_BAD;
      FSI_OP_QUAD_PP:  c = qe ? CL_QUAD_IN : CL_BAD;
      default:         c = c;
    endcase
    return c;
  endfunction

  // Lanes per clock in the address phase (io) or the data phase.
  function automatic logic [3:0] width(input fsi_class_t c, input logic data);
    case (c)
      CL_DUAL_IO:                      width = FSI_W2;
      CL_QUAD_IO:                      width = FSI_W4;
      CL_DUAL_OUT, CL_DUAL_IN:         width = data ? FSI_W2 : FSI_W1;
      CL_QUAD_OUT, CL_QUAD_IN:         width = data ? FSI_W4 : FSI_W1;
      default:                         width = FSI_W1;
    endcase
  endfunction

  // Whether the data phase drives the lanes.
  function automatic logic drives(input fsi_class_t c);
    drives = c inside {CL_PLAIN, CL_SADDR, CL_DUAL_OUT, CL_DUAL_IO,
                       CL_QUAD_OUT, CL_QUAD_IO};
  endfunction

  // Gather the input bits of one clock, lane3 highest.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] l,
                                          input logic [3:0] w);
    case (w)
      FSI_W4:  shift_in = {sh[3:0], l};
      FSI_W2:  shift_in = {sh[5:0], l[1:0]};
      default: shift_in = {sh[6:0], l[0]};
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    fsi_state_t  state;     // Frame state.
    fsi_class_t  cls;       // Class of the current opcode.
    logic        sclk_q;    // Clock level one cycle back.
    logic        cs_q;      // Select level one cycle back.
    logic        hold;      // Pause in force.
    logic [7:0]  rx_sh;     // Receive shifter.
    logic [3:0]  rx_cnt;    // Bits received in this byte.
    logic [1:0]  a_cnt;     // Address bytes received.
    logic [7:0]  tx_sh;     // Transmit shifter.
    logic [3:0]  tx_cnt;    // Bits left in this byte.
    logic        push_v;    // Byte offered to the FIFO.
    logic [8:0]  push_d;    // Offered byte with opcode mark.
    logic        ovr;       // Byte lost to a full FIFO.
    logic        room;      // Copy of FIFO room.
    logic [3:0]  lo;        // Lane output levels.
    logic [3:0]  loe;       // Lane output enables.
    logic        busy;      // Engine busy copy.
    logic        cmd_v;     // Opcode accepted pulse.
    logic [7:0]  op;        // Opcode.
    logic        addr_v;    // Address complete pulse.
    logic [23:0] addr;      // Address.
    logic        take;      // Transmit byte taken pulse.
  } fsi_front_t;

  fsi_front_t st;       // Registered state.
  fsi_front_t next_st;  // Next state.

  // ****************************************
  // Frame logic
  // ****************************************

  // Everything runs off edges found in the synchronised clock, so the
  // link clock must stay well under a quarter of the system clock.
  always_comb begin
    logic       sclk;
    logic       cs;
    logic [3:0] l;
    logic       hold_en;
    logic       rise;
    logic       fall;
    logic [3:0] w;
    logic [7:0] src;
    logic [7:0] nb;
    sclk    = pins[0];
    cs      = pins[1];
    l       = pins[5:2];
    hold_en = !four_lane_enable;
    next_st        = st;
    next_st.sclk_q = sclk;
    next_st.cs_q   = cs;
    next_st.push_v = 1'b0;
    next_st.cmd_v  = 1'b0;
    next_st.addr_v = 1'b0;
    next_st.take   = 1'b0;
    next_st.room   = rx_if.ready;
    next_st.busy   = engine_busy;
    // Pause starts and ends while the clock is low; select high or four-lane mode ends it at any clock level.
    if (!hold_en || cs) begin
      next_st.hold = 1'b0;
    end else if (!st.hold && !l[3] && !sclk) begin
      next_st.hold = 1'b1;
    end else if (st.hold && l[3] && !sclk) begin
      next_st.hold = 1'b0;
    end
    // Edges are ignored while paused; the first edge after select may be
    // of either sense, so the clock's idle level does not matter.
    rise = sclk && !st.sclk_q && !st.hold && !next_st.hold;
    fall = !sclk && st.sclk_q && !st.hold && !next_st.hold;
    w    = width(st.cls, st.state == ST_DATA);
    src  = (st.tx_cnt == '0) ? tx_byte : st.tx_sh;
    nb   = shift_in(st.rx_sh, l, w);
    if (cs) begin
      next_st.state = ST_IDLE;
      next_st.loe   = '0;
    end else if (st.cs_q) begin
      next_st.state  = ST_OPC;
      next_st.cls    = CL_BAD;
      next_st.rx_cnt = '0;
      next_st.a_cnt  = '0;
      next_st.tx_cnt = '0;
      next_st.ovr    = 1'b0;
    end else begin
      case (st.state)
        ST_OPC, ST_ADDR: begin
          if (rise) begin
            next_st.rx_sh  = nb;
            next_st.rx_cnt = st.rx_cnt + w;
            if (st.rx_cnt + w == FSI_BYTE_BITS) begin
              next_st.rx_cnt = '0;
              next_st.push_v = 1'b1;
              next_st.push_d = {st.state == ST_OPC, nb};
              if (st.state == ST_OPC) begin
                next_st.op    = nb;
                next_st.cls   = decode(nb, four_lane_enable);
                next_st.cmd_v = next_st.cls != CL_BAD;
                if (next_st.cls == CL_BAD) begin
                  next_st.state  = ST_STANDBY;
                  next_st.push_v = 1'b0;
                end else if (next_st.cls == CL_PLAIN) begin
                  next_st.state = ST_DATA;
                end else begin
                  next_st.state = ST_ADDR;
                end
              end else begin
                next_st.addr  = {st.addr[15:0], nb};
                next_st.a_cnt = st.a_cnt + 2'h1;
                if (st.a_cnt == FSI_ADDR_LAST) begin
                  next_st.addr_v = 1'b1;
                  next_st.state  = ST_DATA;
                end
              end
            end
          end
        end
        ST_DATA: begin
          // Plain single-lane commands keep receiving while they send.
          if (rise && (!drives(st.cls) || w == FSI_W1)) begin
            next_st.rx_sh  = nb;
            next_st.rx_cnt = st.rx_cnt + w;
            if (st.rx_cnt + w == FSI_BYTE_BITS) begin
              next_st.rx_cnt = '0;
              next_st.push_v = 1'b1;
              next_st.push_d = {1'b0, nb};
            end
          end
          if (fall && drives(st.cls)) begin
            next_st.take   = st.tx_cnt == '0;
            next_st.tx_sh  = src << w;
            next_st.tx_cnt = ((st.tx_cnt == '0) ? FSI_BYTE_BITS : st.tx_cnt) - w;
            case (w)
              FSI_W4:  next_st.lo = src[7:4];
              FSI_W2:  next_st.lo = {2'b00, src[7:6]};
              default: next_st.lo = {2'b00, src[7], 1'b0};
            endcase
          end
          case (w)
            FSI_W4:  next_st.loe = drives(st.cls) ? 4'hf : 4'h0;
            FSI_W2:  next_st.loe = drives(st.cls) ? 4'h3 : 4'h0;
            default: next_st.loe = drives(st.cls) ? 4'h2 : 4'h0;
          endcase
        end
        ST_STANDBY: next_st.loe = '0;
        default:    next_st.loe = '0;
      endcase
    end
    if (st.push_v && !rx_if.ready) begin  // Set wins over the clear at select fall.
      next_st.ovr = 1'b1;
    end
    // Release the lanes the moment the pause pin is seen low.
    if (hold_en && !l[3]) begin
      next_st.loe = '0;
    end
  end

  // Register the copy; select is taken as high after reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      st        <= '0;
      st.state  <= ST_IDLE;
      st.cls    <= CL_BAD;
      st.cs_q   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign rx_if.valid = st.push_v;
  assign rx_if.data  = st.push_d;

  assign {lane3_out, lane2_out, lane1_out, lane0_out} = st.lo;
  assign {lane3_oe, lane2_oe, lane1_oe, lane0_oe}     = st.loe;
  assign busy_flag    = st.busy;
  assign cmd_valid    = st.cmd_v;
  assign cmd_opcode   = st.op;
  assign addr_valid   = st.addr_v;
  assign cmd_addr     = st.addr;
  // Address split into page, sector and block numbers.
  assign addr_page       = st.addr[FSI_SECTOR_SHIFT+6:FSI_PAGE_SHIFT];
  assign addr_sector     = st.addr[FSI_SECTOR_SHIFT+6:FSI_SECTOR_SHIFT];
  assign addr_half_block = st.addr[FSI_SECTOR_SHIFT+6:FSI_BLK32_SHIFT];
  assign addr_block      = st.addr[FSI_SECTOR_SHIFT+6:FSI_BLK64_SHIFT];
  assign addr_ok         = st.addr <= FSI_LAST_ADDR;
  assign link_active  = st.state inside {ST_ADDR, ST_DATA};
  assign link_standby = st.state == ST_STANDBY;
  assign paused       = st.hold;
  assign rx_room      = st.room;
  assign rx_overrun   = st.ovr;
  assign tx_take      = st.take;

endmodule

// *** verification/fsi_host_model.sv ***
`timescale 1ns/1ns
// ****************************************
// Host side of the link
// ****************************************
// Drives the link clock, the select and the lanes. The clock stands still outside frames.
module fsi_host_model (
  // System clock paces every link edge.
  input  wire logic       clock,
  // Link pins as seen from the host.
  output logic            serial_clock = 1'b0,
  output logic            select_n     = 1'b1,
  output logic      [3:0] lane_h       = 4'hf
);
  logic idle_hi = 1'b0; // Idle clock level of the current mode.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Clock parks at the mode's idle level before select falls, 80 ns each half.
  task automatic begin_frame(input logic mode3);
    idle_hi = mode3;
    serial_clock <= mode3;
    tick(20);
    select_n <= 1'b0;
    tick(20);
  endtask
  // Data set up while the clock is low, taken on the rise, MSB first on lane0.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_clock <= 1'b0;
      lane_h[0] <= b[i];
      lane_h[1] <= ~lane_h[1];
      tick(20);
      serial_clock <= 1'b1;
      tick(20);
    end
  endtask
  // A released lane0 shows the inverse of its last value, not a held copy.
  task automatic end_frame();
    serial_clock <= idle_hi;
    tick(20);
    select_n <= 1'b1;
    lane_h[0] <= ~lane_h[0];
    tick(40);
  endtask
endmodule

// *** verification/fsi_frontend_sva.sv ***
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module fsi_frontend_sva (
  input logic        clock,
  input logic        reset,
  input logic        engine_busy,
  input logic        busy_flag,
  input logic        four_lane_enable,
  input logic        lane0_oe,
  input logic        lane1_oe,
  input logic        lane3_in,
  input logic        cmd_valid,
  input logic [7:0]  cmd_opcode,
  input logic        addr_valid,
  input logic [23:0] cmd_addr,
  input logic [10:0] addr_page,
  input logic [6:0]  addr_sector,
  input logic [2:0]  addr_block,
  input logic        addr_ok,
  input logic        link_active,
  input logic        link_standby,
  input logic        paused
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_busy_set: assert property (engine_busy |=> busy_flag)
    else $error("busy flag did not follow engine");
  chk_busy_clear: assert property (!engine_busy |=> !busy_flag)
    else $error("busy flag stuck high");
  chk_standby_quiet: assert property (link_standby |-> !lane0_oe && !lane1_oe)
    else $error("lanes driven in standby");
  chk_cmd_active: assert property (cmd_valid |-> ##[0:1] link_active && !link_standby)
    else $error("accepted opcode did not go active");
  chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid [*8])
    else $error("opcode reported twice in one byte");
  chk_pause_quiet: assert property (paused && !lane3_in |-> !lane1_oe)
    else $error("output driven while paused");
  chk_quad_gate: assert property (cmd_valid && !four_lane_enable
    |-> !(cmd_opcode inside {8'h6b, 8'heb, 8'h94, 8'h32}))
    else $error("quad opcode taken without enable");
  chk_quad_no_pause: assert property (four_lane_enable |-> !paused)
    else $error("pause in four-lane mode");
  chk_addr_split: assert property (addr_valid |-> addr_page == cmd_addr[18:8]
    && addr_sector == cmd_addr[18:12] && addr_block == cmd_addr[18:16])
    else $error("address split wrong");
  chk_addr_range: assert property (addr_valid |-> addr_ok == (cmd_addr <= 24'h07ffff))
    else $error("address range flag wrong");
  cov_cmd: cover property (cmd_valid);
  cov_addr: cover property (addr_valid);
  cov_standby: cover property ($rose(link_standby));
  cov_pause: cover property ($rose(paused));
endmodule
bind fsi_frontend fsi_frontend_sva u_fsi_frontend_sva (.clock, .reset, .engine_busy, .busy_flag,
  .four_lane_enable, .lane0_oe, .lane1_oe, .lane3_in, .cmd_valid, .cmd_opcode, .addr_valid,
  .cmd_addr, .addr_page, .addr_sector, .addr_block, .addr_ok, .link_active, .link_standby,
  .paused);

// *** verification/fsi_frontend_bench.sv ***
`timescale 1ns/1ns
// ****************************************
// Testbench
// ****************************************
module fsi_frontend_bench;
  logic        clock, reset, four_lane_enable, engine_busy, rx_ready, rx_hold;
  logic        serial_clock, select_n, busy_flag, cmd_valid, addr_valid, addr_ok;
  logic        lane0_out, lane1_out, lane2_out, lane3_out, lane0_oe, lane1_oe, lane2_oe, lane3_oe;
  logic        link_active, link_standby, paused, rx_valid, rx_room, rx_overrun, tx_take;
  logic [3:0]  lane_h, addr_half_block;
  logic [7:0]  tx_byte, cmd_opcode;
  logic [23:0] cmd_addr;
  logic [10:0] addr_page;
  logic [6:0]  addr_sector;
  logic [2:0]  addr_block;
  logic [8:0]  rx_data;
  int          error_cnt = 0;
  int          n_checks = 0;
  logic [7:0]  q_op[$];  // Opcodes expected to be accepted.
  logic [23:0] q_adr[$]; // Addresses expected to complete.
  logic [8:0]  q_rx[$];  // Opcode bytes expected out of the FIFO.
  // Each wire level merges the device's drive with the host's.
  wire logic lane0_in = lane0_oe ? lane0_out : lane_h[0];
  wire logic lane1_in = lane1_oe ? lane1_out : lane_h[1];
  wire logic lane2_in = lane2_oe ? lane2_out : lane_h[2];
  wire logic lane3_in = lane3_oe ? lane3_out : lane_h[3];
  fsi_frontend #(.DEPTH(8)) u_fsi_frontend (.clock, .reset, .serial_clock, .select_n,
    .lane0_in, .lane0_out, .lane0_oe, .lane1_in, .lane1_out, .lane1_oe, .lane2_in, .lane2_out,
    .lane2_oe, .lane3_in, .lane3_out, .lane3_oe, .four_lane_enable, .engine_busy, .busy_flag,
    .cmd_valid, .cmd_opcode, .addr_valid, .cmd_addr, .addr_page, .addr_sector,
    .addr_half_block, .addr_block, .addr_ok, .link_active, .link_standby, .paused, .rx_valid,
    .rx_ready, .rx_data, .rx_room, .rx_overrun, .tx_byte, .tx_take);
  fsi_host_model u_fsi_host_model (.clock, .serial_clock, .select_n, .lane_h);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Random engine status, send bytes and drain stalls, all on the rising edge.
  always @(posedge clock) begin
    engine_busy <= 1'($urandom);
    tx_byte <= 8'($urandom);
    rx_ready <= !rx_hold && 1'($urandom);
  end
  // Each report takes the oldest note; an unexpected one finds the queue empty.
  always @(posedge clock) if (!reset) begin
    if (cmd_valid) chk("opcode", cmd_opcode, q_op.size() ? q_op.pop_front() : 8'hxx);
    if (addr_valid) begin
      logic [23:0] ea;
      ea = q_adr.size() ? q_adr.pop_front() : 24'hxxxxxx;
      chk("address", cmd_addr, ea);
      chk("in range", addr_ok, ea <= fsi_pkg::FSI_LAST_ADDR);
      chk("sector", addr_sector, ea[18:12]);
      chk("half block", addr_half_block, ea[18:15]);
    end
    if (rx_valid && rx_ready && rx_data[8]) chk("rx opcode", rx_data, q_rx.pop_front());
  end
  // Opcode, then address bytes, then host data bytes; the frame stays open.
  task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] a,
                       input int na, input int nd, input logic ok);
    if (ok) begin
      q_op.push_back(op);
      q_rx.push_back({1'b1, op});
      if (na > 0) q_adr.push_back(a);
    end
    while (busy_flag) @(posedge clock);
    u_fsi_host_model.begin_frame(m3);
    u_fsi_host_model.put_byte(op);
    for (int i = 0; i < na; i++) u_fsi_host_model.put_byte(a[23-8*i -: 8]);
    repeat (nd) u_fsi_host_model.put_byte(8'($urandom));
  endtask
  initial begin
    logic [7:0]  ops[4] = '{8'h03, 8'h0b, 8'h20, 8'hd8};
    logic [23:0] adr[4];
    void'($urandom(32'h0699b432));
    reset = 1'b1;
    four_lane_enable = 1'b0;
    rx_hold = 1'b0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    adr = '{24'($urandom) & 24'h07ffff, 24'h07f000, 24'h07ffff, 24'h080000};
    // Addressed commands in both clock modes, boundary addresses included.
    for (int k = 0; k < 4; k++) begin
      frame(1'(k), ops[k], adr[k], 3, 0, 1'b1);
      u_fsi_host_model.end_frame();
    end
    // Unknown opcode and a quad opcode without enable both fall to standby.
    foreach (ops[k]) if (k < 2) begin
      frame(1'(k), k ? 8'h6b : 8'h00, 24'h0, 0, 0, 1'b0);
      chk("standby", link_standby, 1'b1);
      chk("lane1 released", lane1_oe, 1'b0);
      u_fsi_host_model.end_frame();
    end
    four_lane_enable <= 1'b1;
    frame(1'b0, 8'h6b, 24'h012345, 3, 0, 1'b1);
    u_fsi_host_model.end_frame();
    four_lane_enable <= 1'b0;
    // FIFO filled past its depth while the far side stalls, then drained.
    rx_hold <= 1'b1;
    frame(1'b0, 8'h05, 24'h0, 0, 10, 1'b1);
    u_fsi_host_model.end_frame();
    chk("rx room", rx_room, 1'b0);
    chk("overrun", rx_overrun, 1'b1);
    rx_hold <= 1'b0;
    repeat (200) @(posedge clock);
    chk("drained", rx_valid, 1'b0);
    // Pause during a send, then select rises while paused.
    frame(1'b0, 8'h05, 24'h0, 0, 1, 1'b1);
    u_fsi_host_model.serial_clock <= 1'b0;
    repeat (20) @(posedge clock);
    chk("lane1 driving", lane1_oe, 1'b1);
    u_fsi_host_model.lane_h[3] <= 1'b0;
    repeat (20) @(posedge clock);
    chk("paused", paused, 1'b1);
    chk("lane1 paused", lane1_oe, 1'b0);
    u_fsi_host_model.lane_h[3] <= 1'b1;
    repeat (20) @(posedge clock);
    chk("resumed", paused, 1'b0);
    chk("lane1 back", lane1_oe, 1'b1);
    u_fsi_host_model.lane_h[3] <= 1'b0;
    u_fsi_host_model.end_frame();
    chk("pause cleared", paused, 1'b0);
    u_fsi_host_model.lane_h[3] <= 1'b1;
    repeat (200) @(posedge clock);
    chk("notes left", 24'(q_op.size() + q_adr.size() + q_rx.size()), 24'h0);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    conclude();
  end
endmodule
